//--- common/swu_defines.svh
// Constants for the single-wire UART slave and its general registers.
`ifndef SWU_DEFINES_SVH
`define SWU_DEFINES_SVH
`define SWU_REG_GLOBAL_FAULT_FLAGS 7'h01
`define SWU_REG_WCNT 7'h02
`define SWU_REG_CFG 7'h03
`define SWU_REG_PINS 7'h04
`define SWU_WR_BIT 7
`define SWU_GLOBAL_FAULT_FLAGS_RST 4'h1
`define SWU_WCNT_RST 8'h00
`define SWU_CFG_RST 12'h000
`define SWU_CFG_ADDR 7:0
`define SWU_CFG_DELAY 11:8
`define SWU_SYNC_BYTE 8'h05
`define SWU_MASTER_ADDR 8'hff
`define SWU_CRC_POLY 8'h07
`define SWU_CRC_INIT 8'h00
`define SWU_GAP_BITS 63
`define SWU_RECOVER_BITS 12
`define SWU_RELEASE_BITS 4
`define SWU_DELAY_UNIT 8
`define SWU_GLITCH_CYC 16
`define SWU_LAST_RD 3'h3
`define SWU_LAST_WR 3'h7
`endif

//--- common/swu_pkg.sv
// Types shared by the single-wire UART slave.
package swu_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SYNC = 2'b01,
    RX_BITS = 2'b10,
    RX_RECOVER = 2'b11
  } swu_rx_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_BITS = 2'b10,
    TX_HOLD = 2'b11
  } swu_tx_e;
endpackage : swu_pkg

//--- common/swu_stream_if.sv
// Valid/ready byte stream between the receiver, FIFO and parser.
`timescale 1ns/1ps
interface swu_stream_if #(parameter int W = 9) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport snk(input data, input valid, output ready);
  modport src(output data, output valid, input ready);
endinterface : swu_stream_if

//--- rtl/swu_crc8.sv
// One byte step of the CRC8, bits taken least significant first.
`timescale 1ns/1ps
`include "swu_defines.svh"
module swu_crc8 (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  output logic [7:0] crc_out
);
  always_comb begin
    logic [7:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ `SWU_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : swu_crc8

//--- rtl/swu_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module swu_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  swu_stream_if.snk wr,
  swu_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire logic do_wr = wr.valid && wr.ready;
  wire logic do_rd = rd.valid && rd.ready;
  assign wr.ready = cnt != (AW+1)'(DEPTH);
  assign rd.valid = cnt != '0;
  assign rd.data = mem[rp];
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr.data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      if (do_rd) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : swu_fifo

//--- rtl/swu_slave.sv
// Single-wire UART slave with general configuration and status registers.
`timescale 1ns/1ps
`include "swu_defines.svh"
module swu_slave
  import swu_pkg::*;
#(
  parameter int BT_W = 16,
  parameter logic [15:0] BIT_T_INIT = 16'h0100,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic iface_select,
  input wire logic line_pos_in,
  output logic line_pos_out,
  output logic line_pos_oe,
  input wire logic line_neg_in,
  output logic line_neg_out,
  output logic line_neg_oe,
  input wire logic addr_step,
  input wire logic drv_disable_pin,
  input wire logic [3:0] gpio_level,
  input wire logic line_comparator,
  input wire logic driver1_shutdown,
  input wire logic driver2_shutdown,
  input wire logic pump_undervolt
);
  logic [9:0] s1;
  logic [9:0] s2;
  logic rx_q;
  swu_rx_e rx_st;
  swu_tx_e tx_st;
  logic [BT_W+1:0] meas;
  logic [1:0] falls;
  logic [BT_W-1:0] bit_t;
  logic [BT_W-1:0] tmr;
  logic [3:0] bidx;
  logic [7:0] sh;
  logic first;
  logic in_dg;
  logic rx_err;
  logic push;
  logic [8:0] pdata;
  logic [BT_W+6:0] gap;
  logic [2:0] pidx;
  logic [7:0] paddr;
  logic [7:0] preg;
  logic [31:0] wdata;
  logic [7:0] pcrc;
  logic [7:0] crc_nx;
  logic [3:0] gflags;
  logic [7:0] wcnt;
  logic [11:0] node_config;
  logic [31:0] rd_val;
  logic [55:0] tx_sh;
  logic [7:0] tcur;
  logic [7:0] tcrc;
  logic [7:0] tcrc_nx;
  logic [9:0] tfr;
  logic [2:0] tidx;
  logic [3:0] tbit;
  logic [BT_W-1:0] ttmr;
  logic [6:0] tcnt;
  logic drive;
  logic dg_done;

  swu_stream_if #(.W(9)) fi ();
  swu_stream_if #(.W(9)) fo ();

  swu_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rstn(rstn),
    .wr(fi),
    .rd(fo)
  );

  // Interface, line, address-step, comparator and GPIO pins pass two flip-flops; the three fault inputs go straight to the flags.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 10'h3f0;
      s2 <= 10'h3f0;
      rx_q <= 1'b1;
    end else begin
      s1 <= {iface_select, line_comparator, drv_disable_pin, addr_step,
             line_neg_in, line_pos_in, gpio_level};
      s2 <= s1;
      rx_q <= s2[4];
    end
  end

  wire logic iface_s = s2[9];
  wire logic rx = s2[4];
  wire logic fall = rx_q && !rx;
  wire logic rise = !rx_q && rx;
  wire logic rx_en = iface_s && tx_st == TX_IDLE;
  wire logic [7:0] eff_addr = node_config[`SWU_CFG_ADDR] + {7'h00, s2[6]};
  wire logic [BT_W+6:0] gap_lim = (BT_W+7)'(bit_t) * (BT_W+7)'(`SWU_GAP_BITS);
  wire logic [BT_W+6:0] rec_lim = (BT_W+7)'(bit_t) * (BT_W+7)'(`SWU_RECOVER_BITS);

  assign fi.valid = push;
  assign fi.data = pdata;
  assign fo.ready = tx_st == TX_IDLE;

  // Receiver: measures the bit time from the sync nibble, then samples mid-bit.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st <= RX_IDLE;
      meas <= '0;
      falls <= 2'h0;
      bit_t <= BT_W'(BIT_T_INIT);
      tmr <= '0;
      bidx <= 4'h0;
      sh <= 8'h00;
      first <= 1'b0;
      in_dg <= 1'b0;
      rx_err <= 1'b0;
      push <= 1'b0;
      pdata <= 9'h000;
    end else begin
      rx_err <= 1'b0;
      push <= 1'b0;
      if (dg_done) begin
        in_dg <= 1'b0;
      end
      case (rx_st)
        RX_IDLE: begin
          if (in_dg && gap > gap_lim) begin
            rx_err <= 1'b1;
            rx_st <= RX_RECOVER;
          end else if (fall && rx_en) begin
            if (in_dg && !dg_done) begin
              rx_st <= RX_BITS;
              bidx <= 4'h0;
              tmr <= bit_t + (bit_t >> 1);
            end else begin
              rx_st <= RX_SYNC;
              meas <= '0;
              falls <= 2'h0;
            end
          end
        end
        RX_SYNC: begin
          meas <= meas + 1'b1;
          if ((rise && meas < (BT_W+2)'(`SWU_GLITCH_CYC)) || meas == '1) begin
            rx_err <= 1'b1;
            rx_st <= RX_RECOVER;
          end else if (fall) begin
            falls <= falls + 2'h1;
            if (falls == 2'h1) begin
              bit_t <= BT_W'((meas + 1'b1) >> 2);
              tmr <= BT_W'((meas + 1'b1) >> 3);
              sh <= `SWU_SYNC_BYTE;
              bidx <= 4'h3;
              first <= 1'b1;
              rx_st <= RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (tmr != '0) begin
            tmr <= tmr - 1'b1;
          end else if (bidx == 4'h8) begin
            if (rx && fi.ready) begin
              push <= 1'b1;
              pdata <= {first, sh};
              first <= 1'b0;
              in_dg <= 1'b1;
              rx_st <= RX_IDLE;
            end else begin
              rx_err <= 1'b1;
              rx_st <= RX_RECOVER;
            end
          end else begin
            sh[bidx[2:0]] <= rx;
            bidx <= bidx + 4'h1;
            tmr <= bit_t - 1'b1;
          end
        end
        RX_RECOVER: begin
          in_dg <= 1'b0;
          if (!rx_err && gap >= rec_lim) begin
            rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Gap and idle timer; restarts on each start edge and on any low level in recovery.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap <= '0;
    end else if (fall || rx_err || (rx_st == RX_RECOVER && !rx)) begin
      gap <= '0;
    end else if (gap != '1) begin
      gap <= gap + 1'b1;
    end
  end

  // Parser: drains the FIFO and checks address and CRC of each datagram.
  wire logic pop = fo.valid && fo.ready;
  wire logic [7:0] pb = fo.data[7:0];
  wire logic pf = fo.data[8];
  wire logic plast = pidx == `SWU_LAST_WR || (pidx == `SWU_LAST_RD && !preg[`SWU_WR_BIT]);
  assign dg_done = pop && !pf && pidx != 3'h0 && plast;
  wire logic acc = dg_done && pb == pcrc && paddr == eff_addr && iface_s;
  wire logic wr_acc = acc && preg[`SWU_WR_BIT];
  wire logic rd_acc = acc && !preg[`SWU_WR_BIT];

  swu_crc8 u_rcrc (
    .crc_in(pf ? `SWU_CRC_INIT : pcrc),
    .data(pb),
    .crc_out(crc_nx)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pidx <= 3'h0;
      paddr <= 8'h00;
      preg <= 8'h00;
      wdata <= 32'h00000000;
      pcrc <= 8'h00;
    end else if (rx_err) begin
      pidx <= 3'h0;
    end else if (pop && (pf || pidx != 3'h0)) begin
      pcrc <= crc_nx;
      pidx <= dg_done ? 3'h0 : (pf ? 3'h1 : pidx + 3'h1);
      if (!pf && pidx == 3'h1) begin
        paddr <= pb;
      end
      if (!pf && pidx == 3'h2) begin
        preg <= pb;
      end
      if (!pf && pidx >= 3'h3 && !dg_done) begin
        wdata <= {wdata[23:0], pb};
      end
    end
  end

  // Writable register; read-only addresses ignore writes.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      node_config <= `SWU_CFG_RST;
    end else if (wr_acc && preg[6:0] == `SWU_REG_CFG) begin
      node_config <= wdata[11:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wcnt <= `SWU_WCNT_RST;
    end else if (wr_acc && iface_s) begin
      wcnt <= wcnt + 8'h01;
    end
  end

  // Fault flags are sticky; a new or lasting fault wins over the read clear.
  wire logic gclr = rd_acc && preg[6:0] == `SWU_REG_GLOBAL_FAULT_FLAGS;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gflags <= `SWU_GLOBAL_FAULT_FLAGS_RST;
    end else begin
      gflags <= (gclr ? 4'h0 : gflags)
        | {pump_undervolt, driver2_shutdown, driver1_shutdown, 1'b0};
    end
  end

  always_comb begin
    case (preg[6:0])
      `SWU_REG_GLOBAL_FAULT_FLAGS: rd_val = {28'h0000000, gflags};
      `SWU_REG_WCNT: rd_val = {24'h000000, wcnt};
      `SWU_REG_PINS: rd_val = {23'h000000, s2[8:0]};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Transmitter: reply delay, eight framed bytes, then a short hold before release.
  swu_crc8 u_tcrc (
    .crc_in(tcrc),
    .data(tcur),
    .crc_out(tcrc_nx)
  );

  wire logic ttick = ttmr == '0;
  wire logic [6:0] dly_bits = {node_config[11:9], 1'b1, 3'h0};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st <= TX_IDLE;
      tx_sh <= '0;
      tcur <= 8'h00;
      tcrc <= 8'h00;
      tfr <= 10'h3ff;
      tidx <= 3'h0;
      tbit <= 4'h0;
      ttmr <= '0;
      tcnt <= 7'h00;
      drive <= 1'b0;
    end else if (!iface_s) begin
      tx_st <= TX_IDLE;
      tfr <= 10'h3ff;
      drive <= 1'b0;
    end else begin
      ttmr <= ttick ? bit_t - 1'b1 : ttmr - 1'b1;
      case (tx_st)
        TX_IDLE: begin
          if (rd_acc) begin
            tx_sh <= {`SWU_MASTER_ADDR, 1'b0, preg[6:0], rd_val, 8'h00};
            tcur <= `SWU_SYNC_BYTE;
            tcrc <= `SWU_CRC_INIT;
            tcnt <= 7'h00;
            ttmr <= bit_t - 1'b1;
            tx_st <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (ttick) begin
            tcnt <= tcnt + 7'h01;
            if (tcnt == dly_bits - 7'h01) begin
              tx_st <= TX_BITS;
              drive <= 1'b1;
              tfr <= {1'b1, tcur, 1'b0};
              tidx <= 3'h0;
              tbit <= 4'h0;
            end
          end
        end
        TX_BITS: begin
          if (ttick) begin
            if (tbit == 4'h9) begin
              tcrc <= tcrc_nx;
              tbit <= 4'h0;
              if (tidx == 3'h7) begin
                tx_st <= TX_HOLD;
                tcnt <= 7'h00;
              end else begin
                tcur <= (tidx == 3'h6) ? tcrc_nx : tx_sh[55:48];
                tfr <= {1'b1, (tidx == 3'h6) ? tcrc_nx : tx_sh[55:48], 1'b0};
                tx_sh <= {tx_sh[47:0], 8'h00};
                tidx <= tidx + 3'h1;
              end
            end else begin
              tfr <= {1'b1, tfr[9:1]};
              tbit <= tbit + 4'h1;
            end
          end
        end
        TX_HOLD: begin
          if (ttick) begin
            tcnt <= tcnt + 7'h01;
            if (tcnt == 7'(`SWU_RELEASE_BITS - 1)) begin
              tx_st <= TX_IDLE;
              drive <= 1'b0;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  assign line_pos_out = tfr[0];
  assign line_neg_out = !tfr[0];
  assign line_pos_oe = drive;
  assign line_neg_oe = drive;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_neg_inverse: assert property (
    line_neg_out == !line_pos_out && line_neg_oe == line_pos_oe)
    else $error("Negative line is not the inverse of the positive line.");
  chk_spi_release: assert property (
    !iface_s |=> !line_pos_oe && tx_st == TX_IDLE)
    else $error("Line driven outside UART mode.");
  chk_cnt_write: assert property (
    wr_acc |=> wcnt == $past(wcnt) + 8'h01)
    else $error("Write counter did not step on accepted write.");
  chk_cnt_read: assert property (
    rd_acc |=> $stable(wcnt))
    else $error("Write counter changed on a read.");
  chk_cnt_spi: assert property (
    !iface_s |=> $stable(wcnt))
    else $error("Write counter changed outside UART mode.");
  chk_cfg_write: assert property (
    wr_acc && preg[6:0] == `SWU_REG_CFG |=> node_config == 12'($past(wdata)))
    else $error("Node configuration not written.");
  chk_fault_one: assert property (
    driver1_shutdown |=> gflags[1])
    else $error("Driver one fault flag not set.");
  chk_fault_two: assert property (
    driver2_shutdown && gclr |=> gflags[2])
    else $error("Driver two fault flag cleared while fault present.");
  chk_global_fault_flags_clear: assert property (
    gclr && !driver1_shutdown && !driver2_shutdown && !pump_undervolt |=> gflags == 4'h0)
    else $error("Global flags not cleared by read.");
  chk_reply_start: assert property (
    rd_acc |=> tx_st == TX_WAIT ##1 !drive [*8])
    else $error("Reply started before the delay.");
  chk_idle_release: assert property (
    tx_st == TX_IDLE |-> !line_pos_oe)
    else $error("Line still driven while transmitter idle.");
  chk_addr_match: assert property (
    acc |-> paddr == node_config[7:0] + {7'h00, s2[6]})
    else $error("Datagram accepted for a foreign address.");

  cov_write: cover property (wr_acc);
  cov_reply: cover property (tx_st == TX_HOLD ##1 tx_st == TX_IDLE);
  cov_rx_error: cover property (rx_err);
endmodule : swu_slave

//--- test/swu_master_model.sv
// Bus master model for the single-wire UART slave: sends datagrams and collects replies.
`timescale 1ns/1ps
module swu_master_model #(
  parameter int T = 20
) (
  input wire logic core_clk,
  input wire logic line,
  input wire logic oe,
  output logic tx
);
  logic [7:0] rx_q[$];
  int delay_cyc;
  int hold_cyc;

  initial tx = 1'b1;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (T) @(posedge core_clk);
    end
  endtask : send_byte

  task automatic send_frame(input logic [7:0] b[$], input logic bad_crc);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i]) begin
      c = crc8(c, b[i]);
      send_byte(b[i]);
    end
    send_byte(c ^ {7'h00, bad_crc});
  endtask : send_frame

  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line !== 1'b0 && n < 4 * T) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4 * T) return;
    repeat (T / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (T) @(posedge core_clk);
      b[i] = line;
    end
    repeat (T) @(posedge core_clk);
    ok = (line === 1'b1);
  endtask : recv_byte

  // The line is left idle for 13 bit times afterwards so the slave can recover.
  task automatic get_reply(input int limit);
    logic [7:0] b;
    bit ok;
    int n;
    rx_q.delete();
    n = 0;
    hold_cyc = 0;
    while (oe !== 1'b1 && n < limit) begin
      @(posedge core_clk);
      n++;
    end
    delay_cyc = n;
    for (int k = 0; k < 8 && n < limit; k++) begin
      recv_byte(b, ok);
      if (ok) rx_q.push_back(b);
    end
    while (oe === 1'b1 && hold_cyc < 10 * T) begin
      @(posedge core_clk);
      hold_cyc++;
    end
    repeat (13 * T) @(posedge core_clk);
  endtask : get_reply

  task automatic write_reg(input logic [7:0] a, input logic [6:0] r, input logic [31:0] d,
                           input logic bad);
    logic [7:0] q[$];
    q = '{8'h05, a, {1'b1, r}, d[31:24], d[23:16], d[15:8], d[7:0]};
    send_frame(q, bad);
    repeat (13 * T) @(posedge core_clk);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, input logic [6:0] r, input int limit);
    logic [7:0] q[$];
    q = '{8'h05, a, {1'b0, r}};
    send_frame(q, 1'b0);
    get_reply(limit);
  endtask : read_reg
endmodule : swu_master_model

//--- test/single_wire_uart_slave_config_test.sv
// Self-checking testbench for the single-wire UART slave and its general registers.
`timescale 1ns/1ps
module single_wire_uart_slave_config_test;
  localparam int T = 20;
  logic core_clk, rstn, iface_select, addr_step, drv_disable_pin, line_comparator;
  logic [3:0] gpio_level;
  logic driver1_shutdown, driver2_shutdown, pump_undervolt, m_tx, line, line_neg_in;
  logic line_pos_out, line_pos_oe, line_neg_out, line_neg_oe;
  int fails, total_checks, neg_bad;
  logic [7:0] node, wcnt;
  logic [3:0] code;

  assign line = line_pos_oe ? line_pos_out : m_tx;
  assign line_neg_in = line_neg_oe ? line_neg_out : ~m_tx;

  swu_slave #(.BIT_T_INIT(16'h0010)) uut (
    .core_clk(core_clk), .rstn(rstn), .iface_select(iface_select),
    .line_pos_in(line), .line_pos_out(line_pos_out), .line_pos_oe(line_pos_oe),
    .line_neg_in(line_neg_in), .line_neg_out(line_neg_out), .line_neg_oe(line_neg_oe),
    .addr_step(addr_step), .drv_disable_pin(drv_disable_pin), .gpio_level(gpio_level),
    .line_comparator(line_comparator), .driver1_shutdown(driver1_shutdown),
    .driver2_shutdown(driver2_shutdown), .pump_undervolt(pump_undervolt)
  );

  swu_master_model #(.T(T)) mst (
    .core_clk(core_clk), .line(line), .oe(line_pos_oe), .tx(m_tx)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (rstn === 1'b1 && (line_neg_out !== ~line_pos_out || line_neg_oe !== line_pos_oe)) begin
      neg_bad++;
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_near(input int got, input int exp, input int tol, input string what);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("Error at %0t: %s took %0d cycles, expected %0d", $time, what, got, exp);
    end
  endtask : check_near

  task automatic rd_check(input logic [7:0] a, input logic [6:0] r, input logic [3:0] c,
                          input logic [31:0] exp);
    int dly;
    logic [7:0] crc;
    dly = (c | 4'h1) * 8 * T;
    mst.read_reg(a, r, dly + 4 * T);
    check_val(mst.rx_q.size(), 8, "reply length");
    if (mst.rx_q.size() != 8) return;
    crc = 8'h00;
    for (int i = 0; i < 7; i++) crc = mst.crc8(crc, mst.rx_q[i]);
    check_val(mst.rx_q[0], 8'h05, "reply sync");
    check_val(mst.rx_q[1], 8'hff, "reply address");
    check_val(mst.rx_q[2], {1'b0, r}, "reply register");
    check_val({mst.rx_q[3], mst.rx_q[4], mst.rx_q[5], mst.rx_q[6]}, exp, "reply data");
    check_val(mst.rx_q[7], crc, "reply crc");
    check_near(mst.delay_cyc, dly + 5 - T / 2, T, "reply delay");
    check_near(mst.hold_cyc, T / 2 + 4 * T, T / 2 + 4, "driver release");
  endtask : rd_check

  task automatic rd_none(input logic [7:0] a, input logic [6:0] r);
    mst.read_reg(a, r, 40 * T);
    check_val(mst.rx_q.size(), 0, "unexpected reply");
  endtask : rd_none

  task automatic t_reset();
    rd_check(8'h00, 7'h01, 4'h0, 32'h1);
    rd_check(8'h00, 7'h01, 4'h0, 32'h0);
    rd_check(8'h00, 7'h02, 4'h0, 32'h0);
    rd_check(8'h00, 7'h03, 4'h0, 32'h0);
  endtask : t_reset

  task automatic t_count();
    mst.write_reg(8'h00, 7'h03, 32'h205, 1'b0);
    node = 8'h05;
    code = 4'h2;
    wcnt = 8'h01;
    rd_check(node, 7'h02, code, {24'h0, wcnt});
    rd_check(node, 7'h02, code, {24'h0, wcnt});
    mst.write_reg(node, 7'h02, 32'h55, 1'b0);
    wcnt++;
    rd_check(node, 7'h02, code, {24'h0, wcnt});
    mst.write_reg(node, 7'h03, 32'h233, 1'b1);
    rd_check(node, 7'h02, code, {24'h0, wcnt});
  endtask : t_count

  task automatic t_address();
    gpio_level <= 4'h5;
    rd_none(8'h00, 7'h02);
    addr_step <= 1'b1;
    rd_none(node, 7'h02);
    rd_check(node + 8'h01, 7'h04, code, 32'h55);
    addr_step <= 1'b0;
    gpio_level <= 4'ha;
    drv_disable_pin <= 1'b1;
    line_comparator <= 1'b1;
    rd_check(node, 7'h04, code, 32'h19a);
  endtask : t_address

  task automatic t_flags();
    driver1_shutdown <= 1'b1;
    @(posedge core_clk);
    driver1_shutdown <= 1'b0;
    rd_check(node, 7'h01, code, 32'h2);
    rd_check(node, 7'h01, code, 32'h0);
    driver2_shutdown <= 1'b1;
    rd_check(node, 7'h01, code, 32'h4);
    rd_check(node, 7'h01, code, 32'h4);
    driver2_shutdown <= 1'b0;
    pump_undervolt <= 1'b1;
    @(posedge core_clk);
    pump_undervolt <= 1'b0;
    rd_check(node, 7'h01, code, 32'hc);
    rd_check(node, 7'h01, code, 32'h0);
  endtask : t_flags

  task automatic t_fourwire();
    iface_select <= 1'b0;
    mst.write_reg(node, 7'h03, 32'h209, 1'b0);
    rd_none(node, 7'h02);
    iface_select <= 1'b1;
    repeat (13 * T) @(posedge core_clk);
    rd_check(node, 7'h02, code, {24'h0, wcnt});
  endtask : t_fourwire

  task automatic t_delay();
    logic [3:0] codes[2];
    codes = '{4'h1, 4'hf};
    foreach (codes[i]) begin
      mst.write_reg(node, 7'h03, {20'h0, codes[i], 8'hfd}, 1'b0);
      wcnt++;
      node = 8'hfd;
      rd_check(node, 7'h02, codes[i], {24'h0, wcnt});
    end
  endtask : t_delay

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rstn = 1'b0;
    iface_select = 1'b1;
    addr_step = 1'b0;
    drv_disable_pin = 1'b0;
    line_comparator = 1'b0;
    gpio_level = 4'h0;
    driver1_shutdown = 1'b0;
    driver2_shutdown = 1'b0;
    pump_undervolt = 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge core_clk);
    t_reset();
    t_count();
    t_address();
    t_flags();
    t_fourwire();
    t_delay();
    check_val(neg_bad, 0, "negative line mismatch");
    test_done();
  end

  initial begin
    #2250000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : single_wire_uart_slave_config_test
